// ===== hw/bcef_flags.sv
// Bus-controller event flags, call stack, trap and status checks
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module bcef_flags (
   // Clock, reset, enable
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Instruction sequencer
   input  wire logic        instr_exec,
   input  wire logic [15:0] instr_word,
   input  wire logic        instr_parity_ok,
   input  wire logic [15:0] instr_param,
   output logic             seq_halt,
   // Message engine
   input  wire logic        msg_active,
   input  wire logic        msg_done,
   input  wire logic        msg_broadcast,
   input  wire logic        fmt_strobe,
   input  wire logic [15:0] ctrl_word,
   input  wire logic        cmd_mode,
   input  wire logic        cmd_rtrt,
   input  wire logic        cmd_bcast,
   output logic             block_size_16,
   output logic [2:0]       fmt_mismatch,
   input  wire logic        status_strobe,
   input  wire logic [15:0] status_word,
   input  wire logic [4:0]  expected_rt_addr,
   // Running indicator to the sequencer
   output logic             running_indicator
);

   ////////////////////////////////////////////////////////////////////////////
   // Instruction decode

   function automatic logic is_illegal(input logic [15:0] w, input logic par_ok);
      logic [4:0] op;
      op = w[bcef_pkg::OPCODE_MSB:bcef_pkg::OPCODE_LSB];
      is_illegal = !bcef_pkg::DEFINED_OPCODES[op] || !par_ok ||
                   (w[bcef_pkg::FIXED_MSB:bcef_pkg::FIXED_LSB] !=
                    bcef_pkg::FIXED_FIELD_VALUE);
   endfunction : is_illegal

   function automatic logic is_op(input logic [15:0] w, input logic [4:0] code);
      is_op = (w[bcef_pkg::OPCODE_MSB:bcef_pkg::OPCODE_LSB] == code);
   endfunction : is_op

   logic        illegal_exec;
   logic        call_exec;
   logic        return_exec;
   logic        irq_exec;

   assign illegal_exec = ce && instr_exec && is_illegal(instr_word, instr_parity_ok);
   assign call_exec    = ce && instr_exec && !illegal_exec &&
                         is_op(instr_word, bcef_pkg::SUBROUTINE_CALL_OP);
   assign return_exec  = ce && instr_exec && !illegal_exec &&
                         is_op(instr_word, bcef_pkg::SUBROUTINE_RETURN_INSTR);
   assign irq_exec     = ce && instr_exec && !illegal_exec &&
                         is_op(instr_word, bcef_pkg::IRQ_REQUEST_OP);

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, stretched while ce is low

   logic        dphase;
   logic        dwrite;
   logic [7:0]  dindex;
   logic        addr_ok;
   logic        wr_cond;
   logic        wr_event;
   logic        wr_config;
   logic [15:0] wdata;

   assign hreadyout = ce;
   assign hresp     = 1'b0;
   assign addr_ok   = hsel && hready && ce && htrans[1] && (haddr[31:10] == 22'h000000);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dphase <= 1'b0;
         dwrite <= 1'b0;
         dindex <= 8'h00;
      end else if (ce && hready) begin
         dphase <= hsel && htrans[1];
         dwrite <= hsel && htrans[1] && hwrite;
         dindex <= addr_ok ? haddr[9:2] : 8'hFF;
      end
   end

   assign wdata     = hwdata[15:0];
   assign wr_cond   = ce && dphase && dwrite && (dindex == bcef_pkg::COND_FLAGS_IDX);
   assign wr_event  = ce && dphase && dwrite && (dindex == bcef_pkg::EVENT_FLAGS_IDX);
   assign wr_config = ce && dphase && dwrite && (dindex == bcef_pkg::CONFIG_IDX);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration register

   logic [15:0] config_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         config_reg <= bcef_pkg::CONFIG_RESET;
      end else if (wr_config) begin
         config_reg <= wdata & bcef_pkg::CONFIG_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Call stack depth

   logic [2:0]  stack_depth;
   logic        stack_over;
   logic        stack_under;

   assign stack_over  = call_exec && (stack_depth == bcef_pkg::STACK_MAX);
   assign stack_under = return_exec && (stack_depth == bcef_pkg::STACK_MIN);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stack_depth <= bcef_pkg::STACK_MIN;
      end else if (call_exec && !stack_over) begin
         stack_depth <= stack_depth + 3'h1;
      end else if (return_exec && !stack_under) begin
         stack_depth <= stack_depth - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Running indicator and halt after the current message

   logic [15:0] cond_flags;
   logic        halt_pending;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cond_flags <= bcef_pkg::COND_RESET;
      end else if (illegal_exec) begin
         cond_flags[bcef_pkg::RUNNING_BIT] <= 1'b0;
      end else if (wr_cond) begin
         cond_flags <= wdata & (bcef_pkg::COND_GP_MASK | 16'h8000);
      end
   end

   assign running_indicator = cond_flags[bcef_pkg::RUNNING_BIT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         halt_pending <= 1'b0;
         seq_halt     <= 1'b0;
      end else if (ce) begin
         if (illegal_exec) begin
            halt_pending <= 1'b1;
            seq_halt     <= 1'b0;
         end else if (halt_pending && !msg_active) begin
            halt_pending <= 1'b0;
            seq_halt     <= 1'b1;
         end else if (wr_cond && wdata[bcef_pkg::RUNNING_BIT]) begin
            seq_halt     <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control word format check

   logic [2:0]  fmt_diff;
   logic        fmt_trap;

   // Mismatch never stops the sequencer; stored commands go out as stored
   assign fmt_diff = {ctrl_word[bcef_pkg::CW_MODE_BIT] ^ cmd_mode,
                      ctrl_word[bcef_pkg::CW_RTRT_BIT] ^ cmd_rtrt,
                      ctrl_word[bcef_pkg::CW_BCAST_BIT] ^ cmd_bcast};
   assign fmt_trap = ce && fmt_strobe && config_reg[bcef_pkg::FMT_CHECK_BIT] &&
                     (fmt_diff != 3'h0) &&
                     config_reg[bcef_pkg::TRAP_ENABLE_BIT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fmt_mismatch  <= 3'h0;
         block_size_16 <= 1'b0;
      end else if (ce && fmt_strobe) begin
         fmt_mismatch  <= config_reg[bcef_pkg::FMT_CHECK_BIT] ? fmt_diff : 3'h0;
         block_size_16 <= ctrl_word[bcef_pkg::CW_RTRT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // RT status word check

   logic [10:0] expected_bits;
   logic [10:0] checked_mask;
   logic        status_bad;
   logic        last_me;

   always_comb begin
      expected_bits = 11'h000;
      checked_mask  = bcef_pkg::SW_CHECKED_MASK;
      if (!config_reg[bcef_pkg::BCR_MASK_EN_BIT]) begin
         expected_bits[bcef_pkg::SW_BCR_BIT] = ctrl_word[bcef_pkg::CW_MASK_BCR_BIT];
      end else begin
         checked_mask[bcef_pkg::SW_BCR_BIT] = 1'b0;
      end
   end

   assign status_bad = ce && status_strobe &&
      ((status_word[bcef_pkg::SW_ADDR_MSB:bcef_pkg::SW_ADDR_LSB] != expected_rt_addr) ||
       (((status_word[10:0] ^ expected_bits) & checked_mask) != 11'h000));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_me <= 1'b0;
      end else if (ce && msg_done) begin
         last_me <= 1'b0;
      end else if (ce && status_strobe) begin
         last_me <= status_word[bcef_pkg::SW_ME_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky event flags: write one to clear, a new event wins over the clear

   logic        stack_error_flag;
   logic        trap_flag;
   logic        status_set_flag;
   logic [3:0]  irq_code_field;
   logic        message_error_flag;
   logic        end_of_message_flag;
   logic        msg_err_evt;
   logic        eom_evt;

   assign msg_err_evt = ce && msg_done && !msg_broadcast &&
                        (last_me || (status_strobe && status_word[bcef_pkg::SW_ME_BIT]));
   assign eom_evt     = ce && msg_done;

   function automatic logic next_flag(input logic cur, input logic evt, input logic clr);
      next_flag = evt || (cur && !clr);
   endfunction : next_flag

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stack_error_flag    <= 1'b0;
         trap_flag           <= 1'b0;
         status_set_flag     <= 1'b0;
         message_error_flag  <= 1'b0;
         end_of_message_flag <= 1'b0;
      end else begin
         stack_error_flag    <= next_flag(stack_error_flag, stack_over || stack_under,
                                          wr_event && wdata[bcef_pkg::STACK_ERR_BIT]);
         trap_flag           <= next_flag(trap_flag, illegal_exec || fmt_trap,
                                          wr_event && wdata[bcef_pkg::TRAP_BIT]);
         status_set_flag     <= next_flag(status_set_flag, status_bad,
                                          wr_event && wdata[bcef_pkg::STATUS_SET_BIT]);
         message_error_flag  <= next_flag(message_error_flag, msg_err_evt,
                                          wr_event && wdata[bcef_pkg::MSG_ERR_BIT]);
         end_of_message_flag <= next_flag(end_of_message_flag, eom_evt,
                                          wr_event && wdata[bcef_pkg::EOM_BIT]);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_code_field <= 4'h0;
      end else if (irq_exec) begin
         irq_code_field <= instr_param[3:0];
      end else if (wr_event) begin
         irq_code_field <= irq_code_field &
                           ~wdata[bcef_pkg::IRQ_CODE_MSB:bcef_pkg::IRQ_CODE_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   logic [15:0] event_view;

   assign event_view = {4'h0, stack_error_flag, trap_flag, status_set_flag, irq_code_field,
                        message_error_flag, end_of_message_flag, 3'h0};

   always_comb begin
      hrdata = 32'h0000_0000;
      if (dphase && !dwrite) begin
         case (dindex)
            bcef_pkg::COND_FLAGS_IDX:  hrdata = {16'h0000, cond_flags};
            bcef_pkg::EVENT_FLAGS_IDX: hrdata = {16'h0000, event_view};
            bcef_pkg::CONFIG_IDX:      hrdata = {16'h0000, config_reg};
            bcef_pkg::SEQ_STATUS_IDX:  hrdata = {29'h0000_0000, stack_depth};
            default:                   hrdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence illegal_seen_s;
      illegal_exec && msg_active;
   endsequence

   sequence msg_ends_s;
      (!seq_halt) [*1] ##1 (ce && !msg_active);
   endsequence

   stack_inc_a: assert property (call_exec && !stack_over |=>
      stack_depth == $past(stack_depth) + 3'h1) else $error("call did not raise depth");
   stack_dec_a: assert property (return_exec && !stack_under |=>
      stack_depth == $past(stack_depth) - 3'h1) else $error("return did not lower depth");
   stack_over_a: assert property (stack_over |=>
      stack_error_flag && stack_depth == 3'h7) else $error("overflow not flagged");
   stack_under_a: assert property (stack_under |=>
      stack_error_flag && stack_depth == 3'h0) else $error("underflow not flagged");
   trap_stop_a: assert property (illegal_exec |=>
      trap_flag && !running_indicator) else $error("illegal instruction not trapped");
   halt_after_a: assert property (illegal_seen_s ##1 msg_ends_s |=>
      seq_halt) else $error("halt not raised after message");
   halt_wait_a: assert property (illegal_seen_s ##1 msg_active |=>
      !seq_halt) else $error("halt before message end");
   fmt_trap_a: assert property (fmt_trap && !illegal_exec && !wr_cond |=>
      trap_flag && running_indicator == $past(running_indicator))
      else $error("format trap wrong");
   status_set_a: assert property (status_bad |=>
      status_set_flag) else $error("status set flag missing");
   irq_code_a: assert property (irq_exec |=>
      irq_code_field == $past(instr_param[3:0])) else $error("irq code not loaded");
   msg_err_a: assert property (msg_err_evt |=> message_error_flag)
      else $error("message error flag missing");
   eom_a: assert property (eom_evt |=> end_of_message_flag)
      else $error("end of message flag missing");
   reserved_zero_a: assert property (dphase && !dwrite &&
      dindex == bcef_pkg::EVENT_FLAGS_IDX |-> hrdata[2:0] == 3'h0)
      else $error("reserved bits not zero");
   flag_hold_a: assert property (trap_flag && !wr_event |=> trap_flag)
      else $error("trap flag dropped without clear");

endmodule : bcef_flags

`default_nettype wire

// ===== hw/bcef_pkg.sv
// Constants for the bus-controller event flag logic
package bcef_pkg;

   // Register indices (byte address is four times the index)
   localparam logic [7:0]  COND_FLAGS_IDX    = 8'h37;
   localparam logic [7:0]  EVENT_FLAGS_IDX   = 8'h38;
   localparam logic [7:0]  CONFIG_IDX        = 8'h39;
   localparam logic [7:0]  SEQ_STATUS_IDX    = 8'h3A;

   // Condition-code register fields
   localparam int          RUNNING_BIT       = 15;
   localparam logic [15:0] COND_GP_MASK      = 16'h00FF;
   localparam logic [15:0] COND_RESET        = 16'h0000;

   // Event flag positions
   localparam int          STACK_ERR_BIT     = 11;
   localparam int          TRAP_BIT          = 10;
   localparam int          STATUS_SET_BIT    = 9;
   localparam int          IRQ_CODE_MSB      = 8;
   localparam int          IRQ_CODE_LSB      = 5;
   localparam int          MSG_ERR_BIT       = 4;
   localparam int          EOM_BIT           = 3;
   localparam logic [15:0] EVENT_RESET       = 16'h0000;

   // Configuration register fields
   localparam int          FMT_CHECK_BIT     = 13;
   localparam int          TRAP_ENABLE_BIT   = 10;
   localparam int          BCR_MASK_EN_BIT   = 5;
   localparam logic [15:0] CONFIG_MASK       = 16'h2420;
   localparam logic [15:0] CONFIG_RESET      = 16'h0400;

   // Instruction word layout
   localparam int          OPCODE_MSB        = 15;
   localparam int          OPCODE_LSB        = 11;
   localparam int          FIXED_MSB         = 9;
   localparam int          FIXED_LSB         = 5;
   localparam logic [4:0]  FIXED_FIELD_VALUE = 5'h0A;
   localparam logic [4:0]  SUBROUTINE_CALL_OP     = 5'h0C;
   localparam logic [4:0]  SUBROUTINE_RETURN_INSTR = 5'h0D;
   localparam logic [4:0]  IRQ_REQUEST_OP    = 5'h06;
   localparam logic [31:0] DEFINED_OPCODES   = 32'h0FFF_FFFF;

   // Call stack
   localparam logic [2:0]  STACK_MAX         = 3'h7;
   localparam logic [2:0]  STACK_MIN         = 3'h0;

   // Control word fields
   localparam int          CW_BCAST_BIT      = 0;
   localparam int          CW_RTRT_BIT       = 1;
   localparam int          CW_MODE_BIT       = 2;
   localparam int          CW_MASK_BCR_BIT   = 5;

   // Status word fields
   localparam int          SW_ADDR_MSB       = 15;
   localparam int          SW_ADDR_LSB       = 11;
   localparam int          SW_ME_BIT         = 10;
   localparam int          SW_BCR_BIT        = 4;
   localparam logic [10:0] SW_CHECKED_MASK   = 11'h71F;

   // Bus transfer codes
   localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ        = 2'h3;

endpackage : bcef_pkg

// ===== bench/bcef_host.sv
// Host processor model: single-word register bus master
`timescale 1ns/1ps
`default_nettype none

module bcef_host (
   // Clock
   input  wire logic        hclk,
   // Request to the slave
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   // Slave answer
   input  wire logic        hreadyout,
   input  wire logic [31:0] hrdata
);
   initial begin
      hsel   = 1'h0;
      haddr  = 32'hFFFF_FFFF;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize  = 3'h2;
      hwdata = 32'hA5A5_A5A5;
   end

   // Address phase held until ready, then data phase held until ready
   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'h1;
      haddr  <= addr;
      htrans <= bcef_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      haddr  <= ~addr;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rd = hrdata;
      hsel   <= 1'h0;
      hwdata <= ~wd;
   endtask : xfer
endmodule : bcef_host

`default_nettype wire

// ===== bench/bc_event_flag_logic_tb.sv
// Self-checking bench for the event flag logic
`timescale 1ns/1ps
`default_nettype none

module bc_event_flag_logic_tb;
   typedef struct packed {
      logic [4:0]  op;
      logic [4:0]  fix;
      logic        pok;
      logic [15:0] par;
      logic [15:0] ev;
      logic [2:0]  dep;
      logic        run;
   } bcef_row_type;
   localparam logic [7:0] COND = bcef_pkg::COND_FLAGS_IDX;
   localparam logic [7:0] EVT  = bcef_pkg::EVENT_FLAGS_IDX;
   localparam logic [7:0] CFG  = bcef_pkg::CONFIG_IDX;
   localparam logic [7:0] STS  = bcef_pkg::SEQ_STATUS_IDX;
   logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, instr_exec;
   logic        instr_parity_ok, seq_halt, msg_active, msg_done, msg_broadcast;
   logic        fmt_strobe, cmd_mode, cmd_rtrt, cmd_bcast, block_size_16;
   logic        status_strobe, running_indicator;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [15:0] instr_word, instr_param, ctrl_word, status_word;
   logic [4:0]  expected_rt_addr;
   logic [2:0]  hsize, fmt_mismatch;
   logic [1:0]  htrans;
   int          err_total, check_count, cycles;
   bcef_row_type rows [7];
   logic [15:0] m_sw [7] = '{16'h2800, 16'h3000, 16'h2C00, 16'h2C00, 16'h2810, 16'h2810, 16'h2810};
   logic        m_bc [7] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
   logic        m_c5 [7] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0};
   logic [15:0] m_ev [7] = '{16'h0008, 16'h0208, 16'h0218, 16'h0208, 16'h0008, 16'h0208, 16'h0008};
   logic [15:0] f_cf [3] = '{16'h2400, 16'h2000, 16'h0400};

   bcef_flags u_dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .instr_exec, .instr_word,
      .instr_parity_ok, .instr_param, .seq_halt, .msg_active, .msg_done, .msg_broadcast,
      .fmt_strobe, .ctrl_word, .cmd_mode, .cmd_rtrt, .cmd_bcast, .block_size_16,
      .fmt_mismatch, .status_strobe, .status_word, .expected_rt_addr, .running_indicator);
   bcef_host u_host (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hreadyout,
      .hrdata);

   initial begin
      hclk = 1'h0;
      forever #4 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         err_total++;
         conclude();
      end
   end

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      u_host.xfer(1'h1, {22'h0, idx, 2'h0}, d, rdv);
   endtask : wr

   task automatic rdc(input string n, input logic [7:0] idx, input logic [31:0] e);
      u_host.xfer(1'h0, {22'h0, idx, 2'h0}, 32'h0, rdv);
      chk(n, rdv, e);
   endtask : rdc

   task automatic exec(input logic [15:0] w, input logic ok, input logic [15:0] p);
      @(posedge hclk);
      instr_exec      <= 1'h1;
      instr_word      <= w;
      instr_parity_ok <= ok;
      instr_param     <= p;
      @(posedge hclk);
      instr_exec      <= 1'h0;
      instr_word      <= ~w;
   endtask : exec

   task automatic msg(input logic [15:0] sw, input logic b, input logic c5);
      @(posedge hclk);
      ctrl_word     <= {10'h0, c5, 5'h0};
      status_strobe <= 1'h1;
      status_word   <= sw;
      @(posedge hclk);
      status_strobe <= 1'h0;
      status_word   <= ~sw;
      msg_done      <= 1'h1;
      msg_broadcast <= b;
      @(posedge hclk);
      msg_done      <= 1'h0;
   endtask : msg

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   initial begin
      {hresetn, instr_exec, instr_parity_ok, msg_active, msg_done, msg_broadcast} = 6'h0;
      {fmt_strobe, cmd_mode, cmd_rtrt, cmd_bcast, status_strobe} = 5'h0;
      {instr_word, instr_param, ctrl_word, status_word} = 64'h0;
      err_total   = 0;
      check_count = 0;
      cycles      = 0;
      ce = 1'h1;
      expected_rt_addr = 5'h05;
      rows[0] = '{5'h0C, 5'h0A, 1'h1, 16'h0000, 16'h0000, 3'h1, 1'h1};
      rows[1] = '{5'h0D, 5'h0A, 1'h1, 16'h0000, 16'h0000, 3'h0, 1'h1};
      rows[2] = '{5'h0D, 5'h0A, 1'h1, 16'h0000, 16'h0800, 3'h0, 1'h1};
      rows[3] = '{5'h06, 5'h0A, 1'h1, 16'h00AB, 16'h0160, 3'h0, 1'h1};
      rows[4] = '{5'h1C, 5'h0A, 1'h1, 16'h0000, 16'h0400, 3'h0, 1'h0};
      rows[5] = '{5'h06, 5'h0B, 1'h1, 16'h0005, 16'h0400, 3'h0, 1'h0};
      rows[6] = '{5'h06, 5'h0A, 1'h0, 16'h0005, 16'h0400, 3'h0, 1'h0};
      repeat (8) @(posedge hclk);
      hresetn <= 1'h1;
      rdc("config", CFG, 32'h0400);
      foreach (rows[i]) begin
         wr(COND, 32'h8000);
         wr(EVT, 32'hFFFF);
         exec({rows[i].op, 1'h0, rows[i].fix, 5'h0}, rows[i].pok, rows[i].par);
         rdc("event", EVT, {16'h0, rows[i].ev});
         rdc("depth", STS, {29'h0, rows[i].dep});
         rdc("cond", COND, {16'h0, rows[i].run, 15'h0});
         chk("run", {31'h0, running_indicator}, {31'h0, rows[i].run});
         chk("halt", {31'h0, seq_halt}, {31'h0, ~rows[i].run});
      end
      // Call stack pushed past its top
      wr(EVT, 32'hFFFF);
      repeat (8) exec(16'h6140, 1'h1, 16'h0);
      rdc("depth", STS, 32'h7);
      rdc("event", EVT, 32'h0800);
      wr(EVT, 32'h0807);
      rdc("event", EVT, 32'h0);
      // Halt waits for the message in progress
      wr(COND, 32'h8000);
      @(posedge hclk) msg_active <= 1'h1;
      exec(16'hF940, 1'h1, 16'h0);
      repeat (4) @(posedge hclk);
      chk("halt", {31'h0, seq_halt}, 32'h0);
      msg_active <= 1'h0;
      repeat (3) @(posedge hclk);
      chk("halt", {31'h0, seq_halt}, 32'h1);
      // Message ends right after the illegal instruction
      wr(COND, 32'h8000);
      @(posedge hclk) msg_active <= 1'h1;
      exec(16'hF940, 1'h1, 16'h0);
      msg_active <= 1'h0;
      @(negedge hclk);
      chk("halt", {31'h0, seq_halt}, 32'h0);
      @(negedge hclk);
      chk("halt", {31'h0, seq_halt}, 32'h1);
      // Frozen while the clock enable is low
      wr(EVT, 32'hFFFF);
      @(posedge hclk) ce <= 1'h0;
      exec(16'h6940, 1'h1, 16'h0);
      exec(16'hF940, 1'h1, 16'h0);
      chk("ready", {31'h0, hreadyout}, 32'h0);
      ce <= 1'h1;
      rdc("depth", STS, 32'h7);
      rdc("event", EVT, 32'h0);
      foreach (m_sw[i]) begin
         wr(CFG, (i == 6) ? 32'h0420 : 32'h0400);
         wr(EVT, 32'hFFFF);
         msg(m_sw[i], m_bc[i], m_c5[i]);
         rdc("event", EVT, {16'h0, m_ev[i]});
      end
      // Format check, only enabled for this development run
      wr(COND, 32'h8000);
      foreach (f_cf[i]) begin
         wr(EVT, 32'hFFFF);
         wr(CFG, {16'h0, f_cf[i]});
         @(posedge hclk);
         {fmt_strobe, cmd_mode, cmd_rtrt, cmd_bcast} <= 4'hC;
         ctrl_word <= 16'h0006;
         @(posedge hclk) fmt_strobe <= 1'h0;
         @(posedge hclk);
         chk("mismatch", {29'h0, fmt_mismatch}, (i < 2) ? 32'h2 : 32'h0);
         chk("block16", {31'h0, block_size_16}, 32'h1);
         rdc("event", EVT, (i == 0) ? 32'h0400 : 32'h0);
         rdc("cond", COND, 32'h8000);
      end
      u_host.xfer(1'h1, 32'h0000_0400, 32'hFFFF, rdv);
      u_host.xfer(1'h0, 32'h0000_0400, 32'h0, rdv);
      chk("unmapped", rdv, 32'h0);
      // Reset in mid-run
      exec(16'h3140, 1'h1, 16'h000F);
      @(posedge hclk) hresetn <= 1'h0;
      repeat (2) @(posedge hclk);
      chk("running", {31'h0, running_indicator}, 32'h0);
      chk("block16", {31'h0, block_size_16}, 32'h0);
      chk("mismatch", {29'h0, fmt_mismatch}, 32'h0);
      chk("halt", {31'h0, seq_halt}, 32'h0);
      chk("resp", {31'h0, hresp}, 32'h0);
      hresetn <= 1'h1;
      rdc("event", EVT, 32'h0);
      rdc("depth", STS, 32'h0);
      rdc("cond", COND, 32'h0);
      conclude();
   end
endmodule : bc_event_flag_logic_tb

`default_nettype wire
